// file: bbt_consts.svh
// constants for the baseband trigger and i/q path control block
`ifndef BBT_CONSTS_SVH
`define BBT_CONSTS_SVH

// ----------------------------------------
// trigger source and trigger style codes
// ----------------------------------------
`define BBT_SRC_KEY      2'h0
`define BBT_SRC_BUS      2'h1
`define BBT_SRC_EXT      2'h2
`define BBT_MODE_CONT    2'h0
`define BBT_MODE_SINGLE  2'h1
`define BBT_MODE_GATE    2'h2

// ----------------------------------------
// select codes
// ----------------------------------------
`define BBT_POL_NORMAL   1'h0
`define BBT_POL_INVERT   1'h1
`define BBT_IQSRC_EXT    1'h0
`define BBT_IQSRC_INT    1'h1
`define BBT_ATTN_AUTO    1'h0
`define BBT_ATTN_MANUAL  1'h1

// ----------------------------------------
// attenuation in 0.01 dB steps
// ----------------------------------------
`define BBT_ATTN_MIN     13'h0000
`define BBT_ATTN_MAX     13'h0FA0
`define BBT_ATTN_RESET   13'h04B0

// ----------------------------------------
// data path sizes
// ----------------------------------------
`define BBT_IQ_W         16
`define BBT_FIFO_DEPTH   8

`endif

// file: bbt_pkg.sv
// types shared by the baseband trigger and i/q path control block
`include "bbt_consts.svh"

package bbt_pkg;

  typedef enum logic {
    BBT_IDLE,
    BBT_RUN
  } bbt_run_t;

  typedef logic [`BBT_IQ_W-1:0] bbt_sample_t;

endpackage

// file: bbt_iq_path.sv
// baseband trigger selection, bit encoder and i/q routing to the modulator
`include "bbt_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// sample fifo
// ----------------------------------------
module bbt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // draining side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          inRdy;
    logic          outVld;
  } bbt_fifo_st_t;

  bbt_fifo_st_t     st_r;
  bbt_fifo_st_t     st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign push     = inValid & st_r.inRdy;
  assign pop      = outReady & st_r.outVld;
  assign inReady  = st_r.inRdy;
  assign outValid = st_r.outVld;
  assign outData  = mem[st_r.rp];

  always_comb begin
    st_nxt        = st_r;
    st_nxt.cnt    = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    st_nxt.inRdy  = st_nxt.cnt != (AW+1)'(DEPTH);
    st_nxt.outVld = st_nxt.cnt != '0;
    if (push) begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + AW'(1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + AW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r       <= '0;
      st_r.inRdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[st_r.wp] <= inData;
    end
  end

  fifo_level_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_r.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

// ----------------------------------------
// top level
// ----------------------------------------
module bbt_iq_path
  import bbt_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // trigger sources
  input  wire logic [1:0]  trigSource,
  input  wire logic [1:0]  trigMode,
  input  wire logic        trigKeyPin,
  input  wire logic        busGetPulse,
  input  wire logic        busTrgCmd,
  input  wire logic        extTrigPin,
  input  wire logic        gatePin,
  input  wire logic        runStop,
  output logic             trigEvent,
  output logic             running,
  // data bit stream
  input  wire logic        diff_encode_enable,
  input  wire logic        bitValid,
  input  wire logic        bitIn,
  input  wire logic        bitLast,
  output logic             bitReady,
  output logic             encValid,
  output logic             encBit,
  // clock selection
  input  wire logic        sampleClkExtSel,
  input  wire logic        dataClkExtSel,
  input  wire logic        dataSourceExt,
  input  wire logic [31:0] symbol_rate_setting,
  input  wire logic [2:0]  symbolBits,
  input  wire logic [31:0] dataClkFreqSetting,
  output logic             sampleClkExt,
  output logic             dataClkExt,
  output logic [31:0]      dataClkFreq,
  // i/q samples
  input  wire logic        phaseInvert,
  input  wire logic        intValid,
  input  wire bbt_sample_t intI,
  input  wire bbt_sample_t intQ,
  output logic             intReady,
  input  wire bbt_sample_t extI,
  input  wire bbt_sample_t extQ,
  input  wire logic        iqSrcSel,
  input  wire logic        wideband_input_enable,
  input  wire logic        modEnable,
  input  wire logic        modReady,
  output logic             modOn,
  output logic             wbOn,
  output logic             iqValid,
  output bbt_sample_t      iOut,
  output bbt_sample_t      qOut,
  // attenuation
  input  wire logic        attnManual,
  input  wire logic        attnWrite,
  input  wire logic [15:0] attnWrValue,
  input  wire logic [15:0] attnAutoValue,
  output logic [12:0]      attn
);

  typedef struct packed {
    logic        keyS1;
    logic        keyS2;
    logic        keyPrev;
    logic        extS1;
    logic        extS2;
    logic        extPrev;
    logic        gateS1;
    logic        gateS2;
    bbt_run_t    runSt;
    logic        trigEvt;
    logic        bitRdy;
    logic        prevBit;
    logic        encVld;
    logic        encOut;
    logic        sampExt;
    logic        dataExt;
    logic [31:0] dataFreq;
    logic        modOn;
    logic        wbOn;
    logic        iqVld;
    bbt_sample_t iVal;
    bbt_sample_t qVal;
    logic [12:0] attn;
  } bbt_st_t;

  bbt_st_t     st_r;
  bbt_st_t     st_nxt;
  logic        trigHit;
  logic        bitTake;
  logic        fifoValid;
  logic        fifoPop;
  logic [31:0] fifoData;
  bbt_sample_t qSel;

  function automatic logic [12:0] clampAttn(input logic [15:0] v);
    clampAttn = (v > 16'(`BBT_ATTN_MAX)) ? `BBT_ATTN_MAX : v[12:0];
  endfunction

  // ----------------------------------------
  // internal sample buffer
  // ----------------------------------------
  assign fifoPop = fifoValid & modReady & st_r.modOn & (iqSrcSel == `BBT_IQSRC_INT);

  bbt_fifo #(
    .WIDTH (2*`BBT_IQ_W),
    .DEPTH (`BBT_FIFO_DEPTH)
  ) sampleFifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .inValid  (intValid),
    .inData   ({intI, intQ}),
    .inReady  (intReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoPop)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.keyS1  = trigKeyPin;
    st_nxt.keyS2  = st_r.keyS1;
    st_nxt.keyPrev = st_r.keyS2;
    st_nxt.extS1  = extTrigPin;
    st_nxt.extS2  = st_r.extS1;
    st_nxt.extPrev = st_r.extS2;
    st_nxt.gateS1 = gatePin;
    st_nxt.gateS2 = st_r.gateS1;
    bitTake       = bitValid & st_r.bitRdy;
    qSel          = 16'h0000;
    unique case (trigSource)
      `BBT_SRC_KEY: trigHit = st_r.keyS2 & ~st_r.keyPrev;
      `BBT_SRC_BUS: trigHit = busGetPulse | busTrgCmd;
      `BBT_SRC_EXT: trigHit = st_r.extS2 & ~st_r.extPrev;
      default:      trigHit = 1'b0;
    endcase
    st_nxt.trigEvt = trigHit;

    // run control
    unique case (st_r.runSt)
      BBT_IDLE: begin
        if (trigMode == `BBT_MODE_GATE) begin
          if (st_r.gateS2) begin
            st_nxt.runSt = BBT_RUN;
          end
        end else if (trigHit && trigMode != 2'h3) begin
          st_nxt.runSt = BBT_RUN;
        end
      end
      BBT_RUN: begin
        if (runStop) begin
          st_nxt.runSt = BBT_IDLE;
        end else if (trigMode == `BBT_MODE_GATE && !st_r.gateS2) begin
          st_nxt.runSt = BBT_IDLE;
        end else if (trigMode == `BBT_MODE_SINGLE && bitTake && bitLast) begin
          st_nxt.runSt = BBT_IDLE;
        end
      end
    endcase
    st_nxt.bitRdy = st_nxt.runSt == BBT_RUN;

    // bit encoder
    st_nxt.encVld = bitTake;
    if (bitTake) begin
      st_nxt.encOut = diff_encode_enable ? (bitIn ^ st_r.prevBit) : bitIn;
      st_nxt.prevBit = bitLast ? 1'b0 : bitIn;
    end
    if (st_r.runSt == BBT_IDLE) begin
      st_nxt.prevBit = 1'b0;
    end

    // clock selection
    st_nxt.sampExt  = sampleClkExtSel;
    st_nxt.dataExt  = dataClkExtSel;
    st_nxt.dataFreq = dataSourceExt ?
                      32'(symbol_rate_setting * 35'(symbolBits)) :
                      dataClkFreqSetting;

    // i/q routing
    st_nxt.modOn = modEnable;
    st_nxt.wbOn  = wideband_input_enable;
    st_nxt.iqVld = 1'b0;
    if (st_r.modOn) begin
      if (iqSrcSel == `BBT_IQSRC_INT) begin
        if (fifoPop) begin
          qSel = fifoData[`BBT_IQ_W-1:0];
          st_nxt.iVal  = fifoData[2*`BBT_IQ_W-1:`BBT_IQ_W];
          st_nxt.qVal  = (phaseInvert == `BBT_POL_INVERT) ? -qSel : qSel;
          st_nxt.iqVld = 1'b1;
        end
      end else if (st_r.wbOn && modReady) begin
        st_nxt.iVal  = extI;
        st_nxt.qVal  = extQ;
        st_nxt.iqVld = 1'b1;
      end
    end

    // attenuation, independent of any i/q adjustment setting
    if (attnManual == `BBT_ATTN_MANUAL) begin
      if (attnWrite) begin
        st_nxt.attn = clampAttn(attnWrValue);
      end
    end else begin
      st_nxt.attn = clampAttn(attnAutoValue);
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= '0;
      st_r.attn <= `BBT_ATTN_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trigEvent    = st_r.trigEvt;
  assign running      = st_r.bitRdy;
  assign bitReady     = st_r.bitRdy;
  assign encValid     = st_r.encVld;
  assign encBit       = st_r.encOut;
  assign sampleClkExt = st_r.sampExt;
  assign dataClkExt   = st_r.dataExt;
  assign dataClkFreq  = st_r.dataFreq;
  assign modOn        = st_r.modOn;
  assign wbOn         = st_r.wbOn;
  assign iqValid      = st_r.iqVld;
  assign iOut         = st_r.iVal;
  assign qOut         = st_r.qVal;
  assign attn         = st_r.attn;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence singleLastSeq;
    st_r.runSt == BBT_RUN && trigMode == `BBT_MODE_SINGLE && !runStop &&
    bitTake && bitLast;
  endsequence

  sequence backIdleSeq;
    st_r.runSt == BBT_IDLE && !bitReady;
  endsequence

  key_trigger_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    trigSource == `BBT_SRC_KEY && trigMode == `BBT_MODE_CONT &&
    st_r.runSt == BBT_IDLE && st_r.keyS2 && !st_r.keyPrev |=> running)
    else $error("key press did not start baseband");

  bus_trigger_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    trigSource == `BBT_SRC_BUS && (busGetPulse || busTrgCmd) |=> trigEvent)
    else $error("bus trigger not taken");

  src_decode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    trigSource == `BBT_SRC_KEY && !st_r.keyS2 |=> !trigEvent)
    else $error("trigger from unselected source");

  ext_trigger_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    trigSource == `BBT_SRC_EXT && $rose(extTrigPin) |-> ##3 trigEvent)
    else $error("rear trigger edge not seen after sync");

  q_invert_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    fifoPop && phaseInvert |=> qOut == -$past(fifoData[15:0]) && iqValid)
    else $error("q channel not negated");

  diff_encode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    bitTake && diff_encode_enable |=>
      encValid && encBit == ($past(bitIn) ^ $past(st_r.prevBit)))
    else $error("differential bit wrong");

  enc_bypass_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    bitTake && !diff_encode_enable |=> encBit == $past(bitIn))
    else $error("bit altered with encoder off");

  first_bit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_r.runSt == BBT_IDLE |=> !st_r.prevBit)
    else $error("previous bit not cleared between sequences");

  clk_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !sampleClkExtSel [*2] |-> ##1 !sampleClkExt)
    else $error("sample clock not internal");

  mod_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !modEnable |-> ##2 !iqValid)
    else $error("sample sent with modulator off");

  ext_route_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    iqSrcSel == `BBT_IQSRC_EXT && st_r.modOn && st_r.wbOn && modReady |=>
      iqValid && iOut == $past(extI) && qOut == $past(extQ))
    else $error("external sample not routed");

  attn_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    attnManual && !attnWrite |=> $stable(attn))
    else $error("manual attenuation changed without write");

  attn_auto_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !attnManual |=> attn == clampAttn($past(attnAutoValue)))
    else $error("auto attenuation not followed");

  attn_range_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    attn <= `BBT_ATTN_MAX)
    else $error("attenuation above limit");

  single_stop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    singleLastSeq |=> backIdleSeq)
    else $error("single run did not stop after last bit");

endmodule

`default_nettype wire

// file: bbt_mod_model.sv
// modulator side model: takes samples, stalls or accepts every other cycle on request
`timescale 1ns/1ps
`default_nettype none

module bbt_mod_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // behaviour control from the bench
  input  wire logic stall,
  input  wire logic slow,
  // modulator port
  input  wire logic iqValid,
  output var logic  modReady,
  output var int    rxCount
);
  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      modReady <= 1'b0;
      rxCount  <= 0;
    end else begin
      modReady <= stall ? 1'b0 : (slow ? ~modReady : 1'b1);
      if (iqValid)
        rxCount <= rxCount + 1;
    end
  end
endmodule

`default_nettype wire

// file: bbt_testbench.sv
// self-checking bench for the baseband trigger and i/q path block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import bbt_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        core_clk, rst_b, stall, slow;
  logic [1:0]  trigSource, trigMode;
  logic        trigKeyPin, busGetPulse, busTrgCmd, extTrigPin, gatePin, runStop;
  logic        trigEvent, running, bitReady, encValid, encBit;
  logic        diff_encode_enable, bitValid, bitIn, bitLast;
  logic        sampleClkExtSel, dataClkExtSel, dataSourceExt, sampleClkExt, dataClkExt;
  logic [31:0] symbol_rate_setting, dataClkFreqSetting, dataClkFreq;
  logic [2:0]  symbolBits;
  logic        phaseInvert, intValid, intReady, iqSrcSel, wideband_input_enable;
  logic        modEnable, modReady, modOn, wbOn, iqValid;
  bbt_sample_t intI, intQ, extI, extQ, iOut, qOut;
  logic        attnManual, attnWrite;
  logic [15:0] attnWrValue, attnAutoValue;
  logic [12:0] attn;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          rxCount;

  bbt_iq_path i_bbt_iq_path (
    .core_clk(core_clk), .rst_b(rst_b), .trigSource(trigSource), .trigMode(trigMode),
    .trigKeyPin(trigKeyPin), .busGetPulse(busGetPulse), .busTrgCmd(busTrgCmd),
    .extTrigPin(extTrigPin), .gatePin(gatePin), .runStop(runStop), .trigEvent(trigEvent),
    .running(running), .diff_encode_enable(diff_encode_enable), .bitValid(bitValid),
    .bitIn(bitIn), .bitLast(bitLast), .bitReady(bitReady), .encValid(encValid),
    .encBit(encBit), .sampleClkExtSel(sampleClkExtSel), .dataClkExtSel(dataClkExtSel),
    .dataSourceExt(dataSourceExt), .symbol_rate_setting(symbol_rate_setting),
    .symbolBits(symbolBits), .dataClkFreqSetting(dataClkFreqSetting),
    .sampleClkExt(sampleClkExt), .dataClkExt(dataClkExt), .dataClkFreq(dataClkFreq),
    .phaseInvert(phaseInvert), .intValid(intValid), .intI(intI), .intQ(intQ),
    .intReady(intReady), .extI(extI), .extQ(extQ), .iqSrcSel(iqSrcSel),
    .wideband_input_enable(wideband_input_enable), .modEnable(modEnable),
    .modReady(modReady), .modOn(modOn), .wbOn(wbOn), .iqValid(iqValid), .iOut(iOut),
    .qOut(qOut), .attnManual(attnManual), .attnWrite(attnWrite),
    .attnWrValue(attnWrValue), .attnAutoValue(attnAutoValue), .attn(attn));
  bbt_mod_model i_bbt_mod_model (.core_clk(core_clk), .rst_b(rst_b), .stall(stall),
    .slow(slow), .iqValid(iqValid), .modReady(modReady), .rxCount(rxCount));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic step(int n = 1);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wait_ev(output logic hit);
    hit = 1'b0;
    repeat (8) begin
      step();
      busGetPulse = 1'b0;
      busTrgCmd   = 1'b0;
      if (trigEvent === 1'b1)
        hit = 1'b1;
    end
  endtask

  task automatic wait_run(input logic v);
    for (int i = 0; i < 8 && running !== v; i++)
      step();
  endtask

  task automatic wait_iq(output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 10 && !hit; i++) begin
      step();
      hit = (iqValid === 1'b1);
    end
  endtask

  task automatic send_bits(input logic [3:0] b, input logic [3:0] e, input logic last);
    for (int i = 3; i >= 0; i--) begin
      bitValid = 1'b1;
      bitIn    = b[i];
      bitLast  = last && i == 0;
      step();
      chk("encValid", 1, encValid);
      chk("encBit", e[i], encBit);
    end
    bitValid = 1'b0;
    bitLast  = 1'b0;
    // one idle cycle so the next call does not re-raise valid in this step
    step();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("attn", 13'h04B0, attn);
    chk("sampleClkExt", 0, sampleClkExt);
    chk("dataClkExt", 0, dataClkExt);
    chk("running", 0, running);
    $display("test reset done");
  endtask

  task automatic t_trig();
    logic hit;
    trigMode = 2'h3;
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 3; k++) begin
        trigSource  = s[1:0];
        trigKeyPin  = (k == 0);
        busGetPulse = (k == 1);
        extTrigPin  = (k == 2);
        wait_ev(hit);
        chk("trigEvent", 32'(k == s), 32'(hit));
        trigKeyPin = 1'b0;
        extTrigPin = 1'b0;
        step(4);
      end
    trigSource = 2'h0;
    trigMode   = 2'h0;
    trigKeyPin = 1'b1;
    wait_run(1'b1);
    chk("running", 1, running);
    runStop = 1'b1;
    step();
    runStop    = 1'b0;
    trigKeyPin = 1'b0;
    chk("running", 0, running);
    $display("test trig done");
  endtask

  task automatic t_enc();
    trigSource  = 2'h1;
    trigMode    = 2'h0;
    busGetPulse = 1'b1;
    step();
    busGetPulse = 1'b0;
    chk("running", 1, running);
    diff_encode_enable = 1'b1;
    send_bits(4'b1010, 4'b1111, 1'b0);
    send_bits(4'b1011, 4'b1110, 1'b1);
    send_bits(4'b1000, 4'b1100, 1'b0);
    chk("running", 1, running);
    diff_encode_enable = 1'b0;
    send_bits(4'b1001, 4'b1001, 1'b0);
    runStop = 1'b1;
    step();
    runStop = 1'b0;
    chk("running", 0, running);
    trigMode  = 2'h1;
    busTrgCmd = 1'b1;
    step();
    busTrgCmd = 1'b0;
    chk("running", 1, running);
    send_bits(4'b0001, 4'b0001, 1'b1);
    chk("running", 0, running);
    chk("bitReady", 0, bitReady);
    trigMode = 2'h2;
    gatePin  = 1'b1;
    wait_run(1'b1);
    chk("running", 1, running);
    gatePin = 1'b0;
    wait_run(1'b0);
    chk("running", 0, running);
    $display("test encoder done");
  endtask

  task automatic t_iq();
    logic hit;
    int   n;
    n         = 0;
    iqSrcSel  = 1'b1;
    modEnable = 1'b1;
    phaseInvert = 1'b1;
    stall     = 1'b1;
    intValid  = 1'b1;
    for (int i = 0; i < 8; i++) begin
      intI = bbt_sample_t'(16'h0100 + i);
      intQ = 16'h0010;
      step();
    end
    intValid = 1'b0;
    chk("intReady", 0, intReady);
    slow  = 1'b1;
    stall = 1'b0;
    for (int c = 0; c < 40 && n < 8; c++) begin
      step();
      if (iqValid === 1'b1) begin
        chk("iOut", 16'h0100 + n, iOut);
        chk("qOut", 16'hFFF0, qOut);
        n++;
      end
    end
    chk("drained", 8, n);
    chk("intReady", 1, intReady);
    slow        = 1'b0;
    phaseInvert = 1'b0;
    modEnable   = 1'b0;
    step(2);
    chk("rxCount", 8, rxCount);
    intI     = 16'h0ABC;
    intQ     = 16'h1234;
    intValid = 1'b1;
    step();
    intValid = 1'b0;
    wait_iq(hit);
    chk("iqValid", 0, hit);
    chk("modOn", 0, modOn);
    modEnable = 1'b1;
    wait_iq(hit);
    chk("iqValid", 1, hit);
    chk("modOn", 1, modOn);
    chk("qOut", 16'h1234, qOut);
    iqSrcSel    = 1'b0;
    wideband_input_enable = 1'b1;
    extI        = 16'h2222;
    extQ        = 16'h3333;
    wait_iq(hit);
    chk("iOut", 16'h2222, iOut);
    chk("qOut", 16'h3333, qOut);
    chk("wbOn", 1, wbOn);
    wideband_input_enable = 1'b0;
    step(3);
    wait_iq(hit);
    chk("iqValid", 0, hit);
    chk("wbOn", 0, wbOn);
    $display("test iq done");
  endtask

  task automatic t_cfg();
    attnManual  = 1'b1;
    attnWrite   = 1'b1;
    attnWrValue = 16'h1388;
    step();
    chk("attn", 13'h0FA0, attn);
    attnWrValue = 16'h03E8;
    step();
    attnWrite = 1'b0;
    chk("attn", 13'h03E8, attn);
    attnManual    = 1'b0;
    attnAutoValue = 16'h0200;
    attnWrite     = 1'b1;
    attnWrValue   = 16'h0100;
    step(2);
    attnWrite = 1'b0;
    chk("attn", 13'h0200, attn);
    attnManual    = 1'b1;
    step();
    attnAutoValue = 16'h0300;
    step(2);
    chk("attn", 13'h0200, attn);
    sampleClkExtSel     = 1'b1;
    dataClkExtSel       = 1'b1;
    dataSourceExt       = 1'b1;
    symbol_rate_setting = 32'h000003E8;
    symbolBits          = 3'h3;
    dataClkFreqSetting  = 32'h00000055;
    step();
    chk("sampleClkExt", 1, sampleClkExt);
    chk("dataClkExt", 1, dataClkExt);
    chk("dataClkFreq", 32'h00000BB8, dataClkFreq);
    dataSourceExt = 1'b0;
    step();
    chk("dataClkFreq", 32'h00000055, dataClkFreq);
    $display("test config done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_b, stall, slow, trigKeyPin, busGetPulse, busTrgCmd, extTrigPin} = '0;
    {gatePin, runStop, diff_encode_enable, bitValid, bitIn, bitLast} = '0;
    {sampleClkExtSel, dataClkExtSel, dataSourceExt, phaseInvert, intValid} = '0;
    {iqSrcSel, wideband_input_enable, modEnable, attnManual, attnWrite} = '0;
    {trigSource, trigMode, symbolBits, symbol_rate_setting, dataClkFreqSetting} = '0;
    {intI, intQ, extI, extQ, attnWrValue, attnAutoValue} = '0;
    repeat (3) @(posedge core_clk);
    #2;
    rst_b = 1'b1;
    t_reset();
    t_trig();
    t_enc();
    t_iq();
    t_cfg();
    report_and_stop();
  end
endmodule

`default_nettype wire
